/* File: verilog/uhb_pkg.sv */
// Package: constants and carriers for the UART host bus and modem pin block
package uhb_pkg;
  // ---------------------------------------------------------------
  // Register selects
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_DATA  = 3'h0;
  localparam logic [2:0] ADDR_LCTRL = 3'h3;
  localparam logic [2:0] ADDR_MCTRL = 3'h4;
  localparam logic [2:0] ADDR_MSTAT = 3'h6;
  localparam logic [2:0] ADDR_SCR   = 3'h7;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MC_TERM_RDY = 0;
  localparam int MC_REQ_SEND = 1;
  localparam int MC_LOOP     = 4;
  localparam int MS_CTS_DLT  = 0;
  localparam int MS_DSR_DLT  = 1;
  localparam int MS_CTS      = 4;
  localparam int MS_DSR      = 5;
  localparam int LC_LEN_LO   = 0;
  localparam int LC_LEN_HI   = 1;
  // Reset values and all-zero / all-one byte constants
  localparam logic [7:0] MCTRL_RST = 8'h00;
  localparam logic [7:0] LCTRL_RST = 8'h03;
  localparam logic [7:0] ZERO8     = 8'h00;
  localparam logic [7:0] FULL8     = 8'hff;
  // Bus access decoded from the pins
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] sel;
    logic [7:0] wdata;
  } uhb_acc_t;
endpackage : uhb_pkg

/* File: verilog/uhb_top.sv */
// UART host bus port, serial output idle control and modem pins
`timescale 1ns/1ps
module uhb_top (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       master_reset,
  input  wire logic       chip_select_a,
  input  wire logic       chip_select_b,
  input  wire logic       chip_select_c_n,
  input  wire logic       read_strobe,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe,
  input  wire logic       write_strobe_n,
  input  wire logic [2:0] register_select,
  input  wire logic [7:0] host_data_bus_in,
  output logic      [7:0] host_data_bus_out,
  output logic            host_data_bus_oe,
  input  wire logic       tx_enable,
  input  wire logic       tx_busy,
  input  wire logic       tx_bit,
  input  wire logic       clear_to_send_n,
  input  wire logic       data_set_ready_n,
  output logic            serial_out,
  output logic            term_ready_n,
  output logic            req_send_n,
  output logic      [7:0] tx_data,
  output logic            tx_load,
  input  wire logic [7:0] rx_data
);
  // ---------------------------------------------------------------
  // Pin synchronisers: first stage read only by the second
  // ---------------------------------------------------------------
  logic [10:0] s1, s2, next_s1, next_s2;
  logic [10:0] raw;
  // Address and data take the same two stages, so they stay aligned with the strobes
  logic [10:0] bus_s1, bus_s2, next_bus_s1, next_bus_s2;
  always_comb begin
    raw = {master_reset, chip_select_a, chip_select_b, chip_select_c_n, read_strobe,
           read_strobe_n, write_strobe, write_strobe_n, tx_busy, clear_to_send_n,
           data_set_ready_n};
    next_s1 = raw;
    next_s2 = s1;
    next_bus_s1 = {register_select, host_data_bus_in};
    next_bus_s2 = bus_s1;
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s1 <= 11'h7ff;
      s2 <= 11'h7ff;
      bus_s1 <= 11'h000;
      bus_s2 <= 11'h000;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      bus_s1 <= next_bus_s1;
      bus_s2 <= next_bus_s2;
    end
  end
  logic mr, cs_ok, rd_lvl, wr_lvl, busy, cts_n, dsr_n;
  assign mr     = s2[10];
  assign cs_ok  = s2[9] & s2[8] & ~s2[7];
  // Host ties the unused polarity inactive, so OR of both is safe
  assign rd_lvl = cs_ok & (s2[6] | ~s2[5]);
  assign wr_lvl = cs_ok & (s2[4] | ~s2[3]);
  assign busy   = s2[2];
  assign cts_n  = s2[1];
  assign dsr_n  = s2[0];
  // ---------------------------------------------------------------
  // Access decode: a write acts once on the strobe's leading edge
  // ---------------------------------------------------------------
  logic wr_d, rd_d, next_wr_d, next_rd_d;
  uhb_pkg::uhb_acc_t acc;
  always_comb begin
    acc.rd    = rd_lvl & ~rd_d;
    acc.wr    = wr_lvl & ~wr_d;
    acc.sel   = bus_s2[10:8];
    acc.wdata = bus_s2[7:0];
    next_wr_d = wr_lvl;
    next_rd_d = rd_lvl;
  end
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] mctrl, lctrl, scr, next_mctrl, next_lctrl, next_scr;
  logic       cts_st, dsr_st, cts_dl, dsr_dl;
  logic       next_cts_st, next_dsr_st, next_cts_dl, next_dsr_dl;
  logic [7:0] next_tx_data, mask, next_rdata, next_mstat;
  logic       next_tx_load, next_oe, next_serial_out, loopb;
  function automatic logic [7:0] len_mask(input logic [1:0] len);
    len_mask = uhb_pkg::FULL8 >> (3'h3 - {1'b0, len});          // 5..8 data bits
  endfunction : len_mask
  always_comb begin
    mask        = len_mask(lctrl[uhb_pkg::LC_LEN_HI:uhb_pkg::LC_LEN_LO]);
    loopb       = mctrl[uhb_pkg::MC_LOOP];
    next_mctrl  = mctrl;
    next_lctrl  = lctrl;
    next_scr    = scr;
    next_tx_data = tx_data;
    next_tx_load = 1'b0;
    // Loopback cuts the CTS pin off, so CTS status freezes; DSR status still follows its pin
    next_cts_st = loopb ? cts_st : ~cts_n;
    next_dsr_st = dsr_n ? 1'b0 : 1'b1;
    next_cts_dl = cts_dl;
    next_dsr_dl = dsr_dl;
    if (acc.rd && acc.sel == uhb_pkg::ADDR_MSTAT) begin
      next_cts_dl = 1'b0;
      next_dsr_dl = 1'b0;
    end
    // Set wins over the read clear so no change is lost
    if (next_cts_st != cts_st) next_cts_dl = 1'b1;
    if (next_dsr_st != dsr_st) next_dsr_dl = 1'b1;
    if (acc.wr) begin
      unique case (acc.sel)
        uhb_pkg::ADDR_DATA: begin
          next_tx_data = acc.wdata & mask;
          next_tx_load = 1'b1;
        end
        uhb_pkg::ADDR_LCTRL: next_lctrl = acc.wdata;
        uhb_pkg::ADDR_MCTRL: next_mctrl = acc.wdata;
        uhb_pkg::ADDR_SCR:   next_scr   = acc.wdata;
        default: ;
      endcase
    end
    next_mstat = uhb_pkg::ZERO8;
    next_mstat[uhb_pkg::MS_CTS]     = cts_st;
    next_mstat[uhb_pkg::MS_DSR]     = dsr_st;
    next_mstat[uhb_pkg::MS_CTS_DLT] = cts_dl;
    next_mstat[uhb_pkg::MS_DSR_DLT] = dsr_dl;
    unique case (acc.sel)
      uhb_pkg::ADDR_DATA:  next_rdata = rx_data & mask;
      uhb_pkg::ADDR_LCTRL: next_rdata = lctrl;
      uhb_pkg::ADDR_MCTRL: next_rdata = mctrl;
      uhb_pkg::ADDR_MSTAT: next_rdata = next_mstat;
      uhb_pkg::ADDR_SCR:   next_rdata = scr;
      default:             next_rdata = uhb_pkg::ZERO8;
    endcase
    // Freeze the word at the strobe's start: a status read clears its flags there
    if (!acc.rd) next_rdata = host_data_bus_out;
    next_oe   = rd_lvl;
    // Bit order is the shifter's: tx_bit carries bit 0 first
    next_serial_out = (~tx_enable | mr | ~busy | loopb)
              ? 1'b1 : tx_bit;
  end
  // ---------------------------------------------------------------
  // State registers; master reset acts like the chip reset here
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst || mr) begin
      mctrl <= uhb_pkg::MCTRL_RST;
      lctrl <= uhb_pkg::LCTRL_RST;
      scr   <= uhb_pkg::ZERO8;
      tx_data <= uhb_pkg::ZERO8;
      tx_load <= 1'b0;
      cts_st <= 1'b0;
      dsr_st <= 1'b0;
      cts_dl <= 1'b0;
      dsr_dl <= 1'b0;
      wr_d <= 1'b0;
      rd_d <= 1'b0;
      host_data_bus_out <= uhb_pkg::ZERO8;
      host_data_bus_oe  <= 1'b0;
      serial_out   <= 1'b1;
      term_ready_n <= 1'b1;
      req_send_n   <= 1'b1;
    end else begin
      mctrl <= next_mctrl;
      lctrl <= next_lctrl;
      scr   <= next_scr;
      tx_data <= next_tx_data;
      tx_load <= next_tx_load;
      cts_st <= next_cts_st;
      dsr_st <= next_dsr_st;
      cts_dl <= next_cts_dl;
      dsr_dl <= next_dsr_dl;
      wr_d <= next_wr_d;
      rd_d <= next_rd_d;
      host_data_bus_out <= next_rdata;
      host_data_bus_oe  <= next_oe;
      serial_out   <= next_serial_out;
      term_ready_n <= ~next_mctrl[uhb_pkg::MC_TERM_RDY];
      req_send_n   <= ~next_mctrl[uhb_pkg::MC_REQ_SEND];
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_oe_follows_read;
    @(posedge clk_sys) disable iff (!nrst || mr) host_data_bus_oe == $past(rd_lvl);
  endproperty
  a_oe_follows_read: assert property (p_oe_follows_read)
    else $error("bus enable wrong");
  property p_no_cs_no_drive;
    @(posedge clk_sys) disable iff (!nrst || mr) !cs_ok |=> !host_data_bus_oe;
  endproperty
  a_no_cs_no_drive: assert property (p_no_cs_no_drive)
    else $error("drive without select");
  property p_mark_idle;
    @(posedge clk_sys) disable iff (!nrst) (!busy || loopb || !tx_enable) |=> serial_out;
  endproperty
  a_mark_idle: assert property (p_mark_idle) else $error("serial out not mark");
  property p_term_ready;
    @(posedge clk_sys) disable iff (!nrst || mr) term_ready_n == !mctrl[uhb_pkg::MC_TERM_RDY];
  endproperty
  a_term_ready: assert property (p_term_ready) else $error("terminal ready wrong");
  property p_req_send;
    @(posedge clk_sys) disable iff (!nrst) mr |=> req_send_n && term_ready_n;
  endproperty
  a_req_send: assert property (p_req_send) else $error("reset did not raise outputs");
  property p_cts_delta;
    @(posedge clk_sys) disable iff (!nrst || mr) $changed(cts_st) |-> cts_dl;
  endproperty
  a_cts_delta: assert property (p_cts_delta) else $error("cts change lost");
  property p_dsr_delta;
    @(posedge clk_sys) disable iff (!nrst || mr) $changed(dsr_st) |-> dsr_dl;
  endproperty
  a_dsr_delta: assert property (p_dsr_delta) else $error("dsr change lost");
  property p_dsr_state;
    @(posedge clk_sys) disable iff (!nrst || mr) $past(nrst && !mr) |-> dsr_st == !$past(dsr_n);
  endproperty
  a_dsr_state: assert property (p_dsr_state) else $error("dsr state wrong");
  // Data masking, loopback freeze and the live serial path
  property p_short_write;
    @(posedge clk_sys) disable iff (!nrst || mr) tx_load |-> (tx_data & ~mask) == uhb_pkg::ZERO8;
  endproperty
  a_short_write: assert property (p_short_write) else $error("masked bits written");
  property p_cts_loop;
    @(posedge clk_sys) disable iff (!nrst || mr) loopb |=> $stable(cts_st);
  endproperty
  a_cts_loop: assert property (p_cts_loop) else $error("cts moved in loopback");
  property p_serial_out_data;
    @(posedge clk_sys) disable iff (!nrst || mr)
      tx_enable && busy && !loopb && !mr |=> serial_out == $past(tx_bit);
  endproperty
  a_serial_out_data: assert property (p_serial_out_data) else $error("serial bit wrong");
endmodule : uhb_top

/* File: sim/uhb_modem.sv */
// Modem partner model: drives the active-low status pins after a delay
`timescale 1ns/1ps
module uhb_modem #(
  parameter int DLY = 2
) (
  input  wire logic clk_sys,
  input  wire logic cts_on,
  input  wire logic dsr_on,
  output logic      clear_to_send_n,
  output logic      data_set_ready_n
);
  logic [7:0] cts_q = 8'h00;
  logic [7:0] dsr_q = 8'h00;
  // Delay line, so the pins move a few cycles after the bench asks
  always @(posedge clk_sys) begin
    cts_q <= {cts_q[6:0], cts_on};
    dsr_q <= {dsr_q[6:0], dsr_on};
  end
  assign clear_to_send_n  = ~cts_q[DLY];  // Asserted line drives low
  assign data_set_ready_n = ~dsr_q[DLY];
endmodule : uhb_modem

/* File: sim/uhb_top_tb.sv */
// Testbench for the host bus port, modem pins and serial idle control
`timescale 1ns/1ps
module uhb_top_tb;
  logic       clk_sys, nrst, master_reset, chip_select_a, chip_select_b, chip_select_c_n;
  logic       read_strobe, write_strobe, tx_enable, tx_busy, tx_bit, cts_on, dsr_on;
  logic       host_data_bus_oe, serial_out, term_ready_n, req_send_n, tx_load;
  logic       clear_to_send_n, data_set_ready_n, ld;
  logic       read_strobe_n, write_strobe_n, lo_pol;
  logic [2:0] register_select;
  logic [7:0] host_data_bus_in, rx_data, host_data_bus_out, tx_data, q;
  int         mismatches = 0;
  int         n_checks = 0;
  uhb_modem #(.DLY(2)) modem_u (.clk_sys(clk_sys), .cts_on(cts_on), .dsr_on(dsr_on),
    .clear_to_send_n(clear_to_send_n), .data_set_ready_n(data_set_ready_n));
  // Unused strobe polarities held inactive
  uhb_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .master_reset(master_reset),
    .chip_select_a(chip_select_a), .chip_select_b(chip_select_b),
    .chip_select_c_n(chip_select_c_n), .read_strobe(read_strobe),
    .read_strobe_n(read_strobe_n), .write_strobe(write_strobe),
    .write_strobe_n(write_strobe_n), .register_select(register_select),
    .host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out),
    .host_data_bus_oe(host_data_bus_oe), .tx_enable(tx_enable), .tx_busy(tx_busy),
    .tx_bit(tx_bit), .clear_to_send_n(clear_to_send_n), .data_set_ready_n(data_set_ready_n),
    .serial_out(serial_out), .term_ready_n(term_ready_n), .req_send_n(req_send_n),
    .tx_data(tx_data), .tx_load(tx_load), .rx_data(rx_data));
  always #5 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp, input string m);
    chk8({7'h00, got}, {7'h00, exp}, m);
  endtask : chk1
  // One bus cycle; tx_load is gathered over the wait so a pulse is not missed
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
                     input logic en);
    chip_select_a = 1'b1;
    chip_select_b = 1'b1;
    chip_select_c_n = ~en;
    register_select = a;
    host_data_bus_in = d;
    read_strobe = ~w & ~lo_pol;  // Polarity not in use stays inactive
    read_strobe_n = w | ~lo_pol;
    write_strobe = w & ~lo_pol;
    write_strobe_n = ~(w & lo_pol);
    ld = 1'b0;
    repeat (3) begin
      step(1);
      ld = ld | tx_load;
    end
    q = host_data_bus_oe === 1'b1 ? host_data_bus_out : 8'hzz;
    read_strobe = 1'b0;
    write_strobe = 1'b0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    chip_select_a = 1'b0;
    step(4);
    chk1(host_data_bus_oe, 1'b0, "bus not released");
  endtask : acc
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00, 1'b1);
    chk8(q, exp, "read data");
  endtask : rd
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_ctrl;
    chk8({4'h0, host_data_bus_oe, serial_out, req_send_n, term_ready_n},
         8'h07, "reset pins");
    acc(1'b1, uhb_pkg::ADDR_MCTRL, 8'h03, 1'b1);
    chk8({6'h00, req_send_n, term_ready_n}, 8'h00, "modem outs on");
    rd(uhb_pkg::ADDR_MCTRL, 8'h03);
    acc(1'b1, uhb_pkg::ADDR_MCTRL, 8'h01, 1'b1);
    chk8({6'h00, req_send_n, term_ready_n}, 8'h02, "rts off");
    master_reset = 1'b1;
    step(4);
    chk8({6'h00, req_send_n, term_ready_n}, 8'h03, "master reset");
    master_reset = 1'b0;
    step(4);
  endtask : t_ctrl
  task automatic t_regs;
    acc(1'b1, uhb_pkg::ADDR_SCR, 8'ha5, 1'b1);
    rd(uhb_pkg::ADDR_SCR, 8'ha5);
    rd(3'h1, 8'h00);
    acc(1'b1, uhb_pkg::ADDR_SCR, 8'h5a, 1'b0);
    acc(1'b0, uhb_pkg::ADDR_SCR, 8'h00, 1'b0);
    chk8(q, 8'hzz, "deselected read drove bus");
    rd(uhb_pkg::ADDR_SCR, 8'ha5);
  endtask : t_regs
  // Active-low strobes, with the active-high pair held inactive
  task automatic t_low;
    lo_pol = 1'b1;
    acc(1'b1, uhb_pkg::ADDR_SCR, 8'h3c, 1'b1);
    rd(uhb_pkg::ADDR_SCR, 8'h3c);
    lo_pol = 1'b0;
  endtask : t_low
  task automatic t_len;
    acc(1'b1, uhb_pkg::ADDR_LCTRL, 8'h00, 1'b1);
    acc(1'b1, uhb_pkg::ADDR_DATA, 8'hff, 1'b1);
    chk8({ld, tx_data[6:0]}, 8'h9f, "short write");
    chk8(tx_data, 8'h1f, "short data");
    rx_data = 8'hff;
    rd(uhb_pkg::ADDR_DATA, 8'h1f);
    acc(1'b1, uhb_pkg::ADDR_LCTRL, 8'h03, 1'b1);
    rx_data = 8'h81;
    rd(uhb_pkg::ADDR_DATA, 8'h81);
  endtask : t_len
  task automatic t_stat;
    rd(uhb_pkg::ADDR_MSTAT, 8'h00);
    cts_on = 1'b1;
    step(6);
    rd(uhb_pkg::ADDR_MSTAT, 8'h11);
    rd(uhb_pkg::ADDR_MSTAT, 8'h10);
    dsr_on = 1'b1;
    step(6);
    rd(uhb_pkg::ADDR_MSTAT, 8'h32);
    cts_on = 1'b0;
    dsr_on = 1'b0;
    step(6);
    rd(uhb_pkg::ADDR_MSTAT, 8'h03);
    rd(uhb_pkg::ADDR_MSTAT, 8'h00);
  endtask : t_stat
  task automatic t_ser;
    tx_enable = 1'b1;
    tx_busy = 1'b1;
    step(6);
    chk1(serial_out, 1'b0, "space with cts off");
    tx_bit = 1'b1;
    step(6);
    chk1(serial_out, 1'b1, "mark");
    tx_bit = 1'b0;
    master_reset = 1'b1;
    step(4);
    chk1(serial_out, 1'b1, "mark in reset");
    master_reset = 1'b0;
    tx_enable = 1'b0;
    step(6);
    chk1(serial_out, 1'b1, "mark disabled");
    tx_enable = 1'b1;
    tx_busy = 1'b0;
    step(6);
    chk1(serial_out, 1'b1, "mark empty");
    tx_busy = 1'b1;
    acc(1'b1, uhb_pkg::ADDR_MCTRL, 8'h10, 1'b1);
    chk1(serial_out, 1'b1, "mark in loop");
    cts_on = 1'b1;
    step(6);
    rd(uhb_pkg::ADDR_MSTAT, 8'h00);
  endtask : t_ser
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  // Watchdog: the sequence needs about 235 cycles
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  initial begin
    {clk_sys, nrst, master_reset, chip_select_a, chip_select_b, chip_select_c_n} = 6'h01;
    {read_strobe, write_strobe, tx_enable, tx_busy, tx_bit, cts_on, dsr_on} = 7'h00;
    {read_strobe_n, write_strobe_n, lo_pol} = 3'h6;
    {register_select, host_data_bus_in, rx_data} = 19'h00000;
    step(3);
    nrst = 1'b1;
    step(3);
    t_ctrl();
    t_regs();
    t_low();
    t_len();
    t_stat();
    t_ser();
    end_sim();
  end
endmodule : uhb_top_tb
